// *** hw/scsi_xfer_timing_control.sv ***
// timing and pacing core: register port, part id, dma threshold, req pacing
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module scsi_xfer_timing_control
    import scsi_timing_pkg::*;
#(
    parameter logic [7:0] PART_ID = 8'hA5 // arbitrary value
) (
    // clock, reset and enable
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic ce,
    // register port
    input wire reg_req_s reg_req,
    output logic [7:0] reg_rdata,
    // scsi fifo state and dma engine
    input wire logic [FIFO_LVL_W-1:0] fifo_level,
    input wire logic xfer_dir_in,
    output logic dma_ready,
    output logic xfer_done,
    // scsi handshake
    input wire logic scsi_ack_n,
    output logic scsi_req_n,
    output logic byte_strobe
);

    logic [PERIOD_W-1:0] period_q;
    logic [PERIOD_W-1:0] eff_period_q;
    logic [CONV_W-1:0] conv_q;
    logic [SYNC_OFF_W-1:0] sync_offset_q;
    logic ext_timing_q;
    logic fast_timing_q;
    logic fast_clock_q;
    logic [CNT_W-1:0] start_cnt_q;
    logic [CNT_W-1:0] cur_cnt_q;
    logic loaded_q;
    logic done_q;
    logic dma_ready_q;
    logic [7:0] rdata_q;
    logic [2:0] setup_q;
    logic ack_meta_q;
    logic ack_sync_q;
    timing_s min_t;
    logic meets_w;
    logic room_w;
    logic go_w;
    logic load_w;
    logic sync_mode_w;
    logic req_n_w;
    logic strobe_w;

    // command decode and mode
    assign load_w = reg_req.we && reg_req.addr == ADDR_CMD && reg_req.wdata[CMD_LOAD_BIT];
    assign sync_mode_w = sync_offset_q != '0;

    // timing configuration registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            period_q <= PERIOD_RESET;
            conv_q <= CONV_RESET;
            sync_offset_q <= '0;
            ext_timing_q <= 1'h0;
            fast_timing_q <= 1'h0;
            fast_clock_q <= 1'h0;
        end else if (ce && reg_req.we) begin
            case (reg_req.addr)
                ADDR_PERIOD: period_q <= reg_req.wdata[PERIOD_W-1:0];
                ADDR_CONV: conv_q <= reg_req.wdata[CONV_W-1:0];
                ADDR_SYNC_OFF: sync_offset_q <= reg_req.wdata[SYNC_OFF_W-1:0];
                ADDR_CTRL1: ext_timing_q <= reg_req.wdata[EXT_TIMING_BIT];
                ADDR_CTRL3: begin
                    fast_timing_q <= reg_req.wdata[FAST_TIMING_BIT];
                    fast_clock_q <= reg_req.wdata[FAST_CLOCK_BIT];
                end
                default: ;
            endcase
        end
    end

    // start transfer count, written a byte at a time
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            start_cnt_q <= '0;
        end else if (ce && reg_req.we) begin
            case (reg_req.addr)
                ADDR_CNT_LO: start_cnt_q[BYTE_W-1:0] <= reg_req.wdata;
                ADDR_CNT_MID: start_cnt_q[2*BYTE_W-1:BYTE_W] <= reg_req.wdata;
                ADDR_CNT_HI: start_cnt_q[CNT_W-1:2*BYTE_W] <= reg_req.wdata;
                default: ;
            endcase
        end
    end

    // current count: load command wins over a byte decrement
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cur_cnt_q <= '0;
            loaded_q <= 1'h0;
        end else if (ce) begin
            if (load_w) begin
                cur_cnt_q <= start_cnt_q;
                loaded_q <= 1'h1;
            end else if (strobe_w && loaded_q && cur_cnt_q != '0) begin
                cur_cnt_q <= cur_cnt_q - CNT_W'(1);
            end
        end
    end

    // transfer complete once a loaded count has run out
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            done_q <= 1'h0;
        end else if (ce) begin
            done_q <= loaded_q && cur_cnt_q == '0;
        end
    end

    // fifo threshold in the current direction
    assign meets_w = xfer_dir_in ? (fifo_level >= FIFO_THRESH)
                                 : ((FIFO_DEPTH - fifo_level) >= FIFO_THRESH);

    // dma ready follows the threshold each enabled cycle, so it falls one clock after the threshold is missed
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            dma_ready_q <= 1'h0;
        end else if (ce) begin
            dma_ready_q <= meets_w;
        end
    end

    // minimum timing lookup
    scsi_timing_table u_table (
        .fast_timing_enable (fast_timing_q),
        .fast_clock_select (fast_clock_q),
        .ext_timing (ext_timing_q),
        .min_t (min_t)
    );

    // effective period: programmed value floored at the minimum; setup: table minimum for the sync or async mode
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            eff_period_q <= PERIOD_RESET;
            setup_q <= SLOW_ASYNC;
        end else if (ce) begin
            if (period_q < PERIOD_W'(min_t.min_period)) begin
                eff_period_q <= PERIOD_W'(min_t.min_period);
            end else begin
                eff_period_q <= period_q;
            end
            setup_q <= sync_mode_w ? min_t.sync_setup : min_t.async_setup;
        end
    end

    // ack pin synchroniser; only the second stage is used
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ack_meta_q <= 1'h0;
            ack_sync_q <= 1'h0;
        end else if (ce) begin
            ack_meta_q <= ~scsi_ack_n;
            ack_sync_q <= ack_meta_q;
        end
    end

    // a byte may move when counted bytes remain and the fifo allows it
    assign room_w = xfer_dir_in ? (fifo_level != FIFO_DEPTH) : (fifo_level != '0);
    assign go_w = loaded_q && cur_cnt_q != '0 && room_w;

    // req pulse generation
    scsi_req_pacer u_pacer (
        .sys_clk (sys_clk),
        .srst (srst),
        .ce (ce),
        .go (go_w),
        .sync_mode (sync_mode_w),
        .setup (setup_q),
        .period (eff_period_q),
        .ack (ack_sync_q),
        .req_n (req_n_w),
        .strobe (strobe_w)
    );

    // read data for one cycle after the read strobe, zero otherwise
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata_q <= '0;
        end else if (ce) begin
            rdata_q <= '0;
            if (reg_req.re) begin
                case (reg_req.addr)
                    ADDR_CNT_LO: rdata_q <= cur_cnt_q[BYTE_W-1:0];
                    ADDR_CNT_MID: rdata_q <= cur_cnt_q[2*BYTE_W-1:BYTE_W];
                    ADDR_CNT_HI: rdata_q <= loaded_q ? cur_cnt_q[CNT_W-1:2*BYTE_W] : PART_ID;
                    ADDR_PERIOD: rdata_q <= BYTE_W'(period_q);
                    ADDR_CONV: rdata_q <= BYTE_W'(conv_q);
                    ADDR_SYNC_OFF: rdata_q <= BYTE_W'(sync_offset_q);
                    ADDR_CTRL1: rdata_q[EXT_TIMING_BIT] <= ext_timing_q;
                    ADDR_CTRL3: begin
                        rdata_q[FAST_TIMING_BIT] <= fast_timing_q;
                        rdata_q[FAST_CLOCK_BIT] <= fast_clock_q;
                    end
                    ADDR_STATUS: begin
                        rdata_q[STAT_LOADED_BIT] <= loaded_q;
                        rdata_q[STAT_DONE_BIT] <= done_q;
                        rdata_q[STAT_DMA_BIT] <= dma_ready_q;
                        rdata_q[STAT_REQ_BIT] <= ~req_n_w;
                    end
                    default: rdata_q <= '0;
                endcase
            end
        end
    end

    // outputs straight from flops
    assign reg_rdata = rdata_q;
    assign dma_ready = dma_ready_q;
    assign xfer_done = done_q;
    assign scsi_req_n = req_n_w;
    assign byte_strobe = strobe_w;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    id_before_load_a: assert property (
        ce && reg_req.re && reg_req.addr == ADDR_CNT_HI && !loaded_q |=> reg_rdata == PART_ID)
        else $error("part id not returned before the counter load");

    id_msb_after_load_a: assert property (
        ce && reg_req.re && reg_req.addr == ADDR_CNT_HI && loaded_q
        |=> reg_rdata == $past(cur_cnt_q[CNT_W-1:2*BYTE_W]))
        else $error("count top byte wrong after load");

    counter_load_a: assert property (
        ce && load_w |=> loaded_q && cur_cnt_q == $past(start_cnt_q))
        else $error("load command did not load the transfer counter");

    ready_at_thresh_a: assert property (
        ce && xfer_dir_in && fifo_level >= FIFO_THRESH |=> dma_ready)
        else $error("dma ready missing with a word in the fifo");

    ready_withdraw_a: assert property (
        ce && !meets_w |=> !dma_ready)
        else $error("dma ready held below the threshold");

    slow_timing_a: assert property (
        !fast_timing_q |-> (ext_timing_q
            ? (min_t.async_setup == SLOW_EXT_ASYNC && min_t.sync_setup == SLOW_EXT_SYNC
               && min_t.min_period == SLOW_EXT_PERIOD)
            : (min_t.async_setup == SLOW_ASYNC && min_t.sync_setup == SLOW_SYNC
               && min_t.min_period == SLOW_PERIOD)))
        else $error("normal timing minimums wrong");

    fast_timing_a: assert property (
        fast_timing_q |-> min_t.async_setup == (ext_timing_q ? FAST_EXT_ASYNC : FAST_ASYNC)
            && min_t.sync_setup == (fast_clock_q ? FCLK_SYNC : FAST_SYNC)
            && min_t.min_period == (fast_clock_q ? FCLK_PERIOD : FAST_PERIOD))
        else $error("fast timing minimums wrong");

    period_floor_a: assert property (
        ce |=> eff_period_q >= PERIOD_W'($past(min_t.min_period))
            && ($past(period_q) < PERIOD_W'($past(min_t.min_period)) || eff_period_q == $past(period_q)))
        else $error("effective period not the floored programmed period");

    count_down_a: assert property (
        ce && strobe_w && loaded_q && !load_w && cur_cnt_q != '0
        |=> cur_cnt_q == $past(cur_cnt_q) - CNT_W'(1))
        else $error("transfer count not decremented per req");

    load_cover_c: cover property (ce && load_w ##[1:40] strobe_w);
    id_read_cover_c: cover property (ce && reg_req.re && reg_req.addr == ADDR_CNT_HI && !loaded_q);
    ready_fall_cover_c: cover property (dma_ready ##1 !dma_ready);
    done_cover_c: cover property ($rose(xfer_done));

endmodule
`default_nettype wire

// *** hw/scsi_timing_pkg.sv ***
// shared constants and types of the scsi transfer timing core
package scsi_timing_pkg;

    // register byte addresses on the plain register port
    localparam logic [7:0] ADDR_CNT_LO = 8'h00;
    localparam logic [7:0] ADDR_CNT_MID = 8'h04;
    localparam logic [7:0] ADDR_CMD = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_PERIOD = 8'h18;
    localparam logic [7:0] ADDR_SYNC_OFF = 8'h1C;
    localparam logic [7:0] ADDR_CTRL1 = 8'h20;
    localparam logic [7:0] ADDR_CONV = 8'h24;
    localparam logic [7:0] ADDR_CTRL3 = 8'h2C;
    localparam logic [7:0] ADDR_CNT_HI = 8'h38;

    // widths and field positions
    localparam int BYTE_W = 8;
    localparam int CNT_W = 24;
    localparam int PERIOD_W = 5;
    localparam int CONV_W = 3;
    localparam int SYNC_OFF_W = 4;
    localparam int FIFO_LVL_W = 5;
    localparam int CMD_LOAD_BIT = 7;
    localparam int EXT_TIMING_BIT = 7;
    localparam int FAST_TIMING_BIT = 3;
    localparam int FAST_CLOCK_BIT = 4;
    localparam int STAT_LOADED_BIT = 7;
    localparam int STAT_DONE_BIT = 6;
    localparam int STAT_DMA_BIT = 5;
    localparam int STAT_REQ_BIT = 4;

    // reset values
    localparam logic [PERIOD_W-1:0] PERIOD_RESET = 5'h05;
    localparam logic [CONV_W-1:0] CONV_RESET = 3'h2;

    // scsi fifo size and dma threshold, in bytes
    localparam logic [FIFO_LVL_W-1:0] FIFO_DEPTH = 5'h10;
    localparam logic [FIFO_LVL_W-1:0] FIFO_THRESH = 5'h02;

    // minimum cycle counts: async setup, sync setup, sync period
    localparam logic [2:0] SLOW_ASYNC = 3'h2;
    localparam logic [2:0] SLOW_SYNC = 3'h2;
    localparam logic [3:0] SLOW_PERIOD = 4'h5;
    localparam logic [2:0] SLOW_EXT_ASYNC = 3'h3;
    localparam logic [2:0] SLOW_EXT_SYNC = 3'h3;
    localparam logic [3:0] SLOW_EXT_PERIOD = 4'h6;
    localparam logic [2:0] FAST_ASYNC = 3'h3;
    localparam logic [2:0] FAST_EXT_ASYNC = 3'h5;
    localparam logic [2:0] FAST_SYNC = 3'h3;
    localparam logic [3:0] FAST_PERIOD = 4'h8;
    localparam logic [2:0] FCLK_SYNC = 3'h2;
    localparam logic [3:0] FCLK_PERIOD = 4'h4;

    typedef struct packed {
        logic [2:0] async_setup;
        logic [2:0] sync_setup;
        logic [3:0] min_period;
    } timing_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } reg_req_s;

endpackage

// *** hw/scsi_timing_table.sv ***
// lookup of minimum setup and period cycles from the timing settings
`timescale 1ns/1ns
`default_nettype none
module scsi_timing_table
    import scsi_timing_pkg::*;
(
    // timing settings
    input wire logic fast_timing_enable,
    input wire logic fast_clock_select,
    input wire logic ext_timing,
    // resulting minimum cycle counts
    output var timing_s min_t
);

    // select the minimum cycles for the current mode
    always_comb begin
        min_t.async_setup = SLOW_ASYNC;
        min_t.sync_setup = SLOW_SYNC;
        min_t.min_period = SLOW_PERIOD;
        if (!fast_timing_enable) begin
            if (ext_timing) begin
                min_t.async_setup = SLOW_EXT_ASYNC;
                min_t.sync_setup = SLOW_EXT_SYNC;
                min_t.min_period = SLOW_EXT_PERIOD;
            end
        end else begin
            min_t.async_setup = ext_timing ? FAST_EXT_ASYNC : FAST_ASYNC;
            if (fast_clock_select) begin
                min_t.sync_setup = FCLK_SYNC;
                min_t.min_period = FCLK_PERIOD;
            end else begin
                min_t.sync_setup = FAST_SYNC;
                min_t.min_period = FAST_PERIOD;
            end
        end
    end

endmodule
`default_nettype wire

// *** hw/scsi_req_pacer.sv ***
// req pulse pacer: data setup, sync period spacing, async ack handshake
`timescale 1ns/1ns
`default_nettype none
module scsi_req_pacer
    import scsi_timing_pkg::*;
(
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic ce,
    // pacing control
    input wire logic go,
    input wire logic sync_mode,
    input wire logic [2:0] setup,
    input wire logic [PERIOD_W-1:0] period,
    input wire logic ack,
    // handshake out
    output logic req_n,
    output logic strobe
);

    typedef enum logic [2:0] {IDLE, SETUP, ASSERT, GAP, ACK_LOW} pace_e;

    pace_e st_q;
    logic [PERIOD_W-1:0] cnt_q;
    logic [5:0] gap_q;
    logic seen_q;

    // pacing state machine; cnt_q counts cycles from go in SETUP, from the leading edge after that
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_q <= IDLE;
            cnt_q <= '0;
            req_n <= 1'h1;
            strobe <= 1'h0;
        end else if (ce) begin
            strobe <= 1'h0;
            case (st_q)
                IDLE: begin
                    if (go) begin
                        st_q <= SETUP;
                        cnt_q <= PERIOD_W'(1);
                    end
                end
                SETUP: begin
                    if (cnt_q >= PERIOD_W'(setup)) begin
                        st_q <= ASSERT;
                        req_n <= 1'h0;
                        strobe <= 1'h1;
                        cnt_q <= PERIOD_W'(1);
                    end else begin
                        cnt_q <= cnt_q + PERIOD_W'(1);
                    end
                end
                ASSERT: begin
                    cnt_q <= cnt_q + PERIOD_W'(1);
                    if (sync_mode && cnt_q >= PERIOD_W'(setup)) begin
                        st_q <= GAP;
                        req_n <= 1'h1;
                    end else if (!sync_mode && ack) begin
                        st_q <= ACK_LOW;
                        req_n <= 1'h1;
                    end
                end
                GAP: begin
                    // next leading edge exactly one period after the last while go holds, otherwise back to IDLE
                    if (cnt_q >= period) begin
                        cnt_q <= PERIOD_W'(1);
                        if (go) begin
                            st_q <= ASSERT;
                            req_n <= 1'h0;
                            strobe <= 1'h1;
                        end else begin
                            st_q <= IDLE;
                        end
                    end else begin
                        cnt_q <= cnt_q + PERIOD_W'(1);
                    end
                end
                ACK_LOW: begin
                    if (!ack) begin
                        st_q <= IDLE;
                    end
                end
                default: st_q <= IDLE;
            endcase
        end
    end

    // helper for the spacing check: cycles since the previous leading edge
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            gap_q <= '0;
            seen_q <= 1'h0;
        end else if (ce) begin
            if (strobe) begin
                gap_q <= 6'h01;
                seen_q <= 1'h1;
            end else if (gap_q != 6'h3F) begin
                gap_q <= gap_q + 6'h01;
            end
        end
    end

    sync_spacing_a: assert property (@(posedge sys_clk) disable iff (srst)
        strobe && seen_q && sync_mode |-> gap_q >= {1'h0, period})
        else $error("req leading edges closer than the sync period");

    req_cover_c: cover property (@(posedge sys_clk) disable iff (srst)
        strobe && seen_q && sync_mode && gap_q == {1'h0, period});

endmodule
`default_nettype wire

// *** tb/scsi_target_model.sv ***
// behavioural scsi target that answers req with ack after a chosen delay
`timescale 1ns/1ns
`default_nettype none
module scsi_target_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // handshake
    input wire logic scsi_req_n,
    input wire logic [3:0] ack_delay,
    output logic scsi_ack_n
);
    logic [3:0] wait_q;

    // ack follows req both ways after ack_delay cycles; terminated line idles high
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            scsi_ack_n <= 1'b1;
            wait_q <= 4'h0;
        end else if (scsi_ack_n == scsi_req_n) begin
            wait_q <= 4'h0;
        end else if (wait_q >= ack_delay) begin
            scsi_ack_n <= scsi_req_n;
            wait_q <= 4'h0;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule
`default_nettype wire

// *** tb/scsi_xfer_timing_control_bench.sv ***
// self-checking bench of the scsi transfer timing core
`timescale 1ns/1ns
`default_nettype none
module scsi_xfer_timing_control_bench;
    import scsi_timing_pkg::*;
    localparam logic [7:0] ID_CODE = 8'h3C; // arbitrary value
    logic sys_clk, srst, ce, xfer_dir_in, scsi_ack_n, dma_ready, xfer_done, scsi_req_n, byte_strobe;
    reg_req_s reg_req;
    logic [7:0] reg_rdata;
    logic [FIFO_LVL_W-1:0] fifo_level;
    logic [3:0] ack_delay;
    int fail_count, checks, cyc, low_cnt;
    int stamps[$];

    scsi_xfer_timing_control #(.PART_ID(ID_CODE)) DUT (.sys_clk(sys_clk), .srst(srst), .ce(ce), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .fifo_level(fifo_level), .xfer_dir_in(xfer_dir_in), .dma_ready(dma_ready),
        .xfer_done(xfer_done), .scsi_ack_n(scsi_ack_n), .scsi_req_n(scsi_req_n), .byte_strobe(byte_strobe));
    scsi_target_model target (.sys_clk(sys_clk), .srst(srst), .scsi_req_n(scsi_req_n), .ack_delay(ack_delay),
        .scsi_ack_n(scsi_ack_n));

    // 125 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // strobe time stamps, req low cycles and the run ceiling
    always @(posedge sys_clk) begin
        cyc++;
        if (byte_strobe === 1'b1) stamps.push_back(cyc);
        if (scsi_req_n === 1'b0) low_cnt++;
        if (cyc == 20000) begin
            fail_count++;
            close_out();
        end
    end

    task automatic close_out();
        if (fail_count == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge sys_clk);
        reg_req.addr <= addr;
        reg_req.wdata <= data;
        reg_req.we <= 1'b1;
        @(posedge sys_clk);
        reg_req.we <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge sys_clk);
        reg_req.addr <= addr;
        reg_req.re <= 1'b1;
        @(posedge sys_clk);
        reg_req.re <= 1'b0;
        #1 data = reg_rdata;
    endtask

    // dma ready follows the two-byte threshold in both directions, one cycle late
    task automatic dma_test();
        logic [4:0] lv [7] = '{5'h00, 5'h02, 5'h01, 5'h10, 5'h0F, 5'h0E, 5'h03};
        for (int d = 0; d < 2; d++) begin
            for (int i = 0; i < 7; i++) begin
                @(posedge sys_clk);
                xfer_dir_in <= d[0];
                fifo_level <= lv[i];
                @(posedge sys_clk);
                #1 check("dma ready", dma_ready, (d == 1) ? (lv[i] >= 5'h02) : (5'h10 - lv[i] >= 5'h02));
            end
        end
        // enable low freezes the ready flop, enable high lets it drop
        @(posedge sys_clk);
        ce <= 1'b0;
        fifo_level <= 5'h00;
        repeat (2) @(posedge sys_clk);
        #1 check("ready frozen", dma_ready, 1'b1);
        @(posedge sys_clk);
        ce <= 1'b1;
        @(posedge sys_clk);
        #1 check("ready after enable", dma_ready, 1'b0);
    endtask

    // id byte before the first load, count byte after it, reset values
    task automatic id_test();
        logic [7:0] rd;
        reg_rd(ADDR_CNT_HI, rd);
        check("part id", rd, ID_CODE);
        reg_rd(ADDR_PERIOD, rd);
        check("period reset", rd, 8'h05);
        reg_rd(ADDR_CONV, rd);
        check("conv reset", rd, 8'h02);
        reg_rd(8'h3C, rd);
        check("unmapped read", rd, 8'h00);
        reg_wr(ADDR_CNT_HI, 8'h5A);
        reg_wr(ADDR_CMD, 8'h80);
        reg_rd(ADDR_CNT_HI, rd);
        check("count top byte", rd, 8'h5A);
        reg_rd(ADDR_STATUS, rd);
        check("status loaded", rd, 8'hA0);
        reg_wr(ADDR_CNT_HI, 8'h00);
        reg_wr(ADDR_CMD, 8'h80);
        reg_rd(ADDR_STATUS, rd);
        check("status done", rd, 8'hE0);
        // a reset in mid-run brings the id byte back
        @(posedge sys_clk);
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        reg_rd(ADDR_CNT_HI, rd);
        check("part id after reset", rd, ID_CODE);
        check("done after reset", xfer_done, 1'b0);
    endtask

    // program the timing, load n bytes and let them go out
    task automatic run_cfg(input logic [7:0] ctrl3, input logic [7:0] ctrl1, input logic [7:0] period,
        input logic [7:0] offset, input logic [7:0] n);
        stamps.delete();
        low_cnt = 0;
        reg_wr(ADDR_CTRL3, ctrl3);
        reg_wr(ADDR_CTRL1, ctrl1);
        reg_wr(ADDR_PERIOD, period);
        reg_wr(ADDR_SYNC_OFF, offset);
        reg_wr(ADDR_CNT_LO, n);
        reg_wr(ADDR_CMD, 8'h80);
        for (int t = 0; t < 600 && stamps.size() < n; t++) @(posedge sys_clk);
        repeat (12) @(posedge sys_clk);
        #1 check("byte count", stamps.size(), n);
        check("done", xfer_done, 1'b1);
    endtask

    // every timing setting in sync mode with the period floored by the table, then programmed periods of 4 and 9
    task automatic sync_test();
        logic [31:0] st, pd;
        for (int i = 0; i < 8; i++) begin
            // i holds fast timing, fast clock and extended timing from msb down
            st = !i[2] ? (i[0] ? 3 : 2) : (i[1] ? 2 : 3);
            pd = !i[2] ? (i[0] ? 6 : 5) : (i[1] ? 4 : 8);
            run_cfg({3'h0, i[1], i[2], 3'h0}, {i[0], 7'h00}, 8'h00, 8'h01, 8'h03);
            check("sync period a", stamps[1] - stamps[0], pd);
            check("sync period b", stamps[2] - stamps[1], pd);
            check("sync setup", low_cnt, 3 * st);
        end
        reg_wr(ADDR_CONV, 8'h00);
        run_cfg(8'h18, 8'h00, 8'h04, 8'h01, 8'h03);
        check("fast period", stamps[1] - stamps[0], 4);
        run_cfg(8'h00, 8'h00, 8'h09, 8'h01, 8'h03);
        check("long period", stamps[2] - stamps[1], 9);
    endtask

    // async setup grows by the table step when extended timing is on
    task automatic async_test();
        int sp [4];
        for (int i = 0; i < 4; i++) begin
            // i holds fast timing then extended timing; fast pair sees a slow target
            @(posedge sys_clk);
            ack_delay <= i[1] ? 4'h3 : 4'h0;
            run_cfg({4'h0, i[1], 3'h0}, {i[0], 7'h00}, 8'h05, 8'h00, 8'h02);
            sp[i] = stamps[1] - stamps[0];
        end
        check("async setup slow", sp[1] - sp[0], 1);
        check("async setup fast", sp[3] - sp[2], 2);
    endtask

    // main sequence
    initial begin
        srst = 1'b1;
        ce = 1'b1;
        reg_req = '0;
        fifo_level = '0;
        xfer_dir_in = 1'b0;
        ack_delay = 4'h0;
        fail_count = 0;
        checks = 0;
        cyc = 0;
        low_cnt = 0;
        repeat (20) @(posedge sys_clk);
        srst <= 1'b0;
        dma_test();
        @(posedge sys_clk);
        fifo_level <= 5'h00;
        xfer_dir_in <= 1'b0;
        id_test();
        @(posedge sys_clk);
        fifo_level <= 5'h10;
        sync_test();
        async_test();
        close_out();
    end
endmodule
`default_nettype wire
